//--- hw/ssu_regs.vh
// Purpose: register offsets, field positions, reset values and counts of the sync serial unit
// Assumes: included by its bare name from ssu_core.v
// Notes: byte offsets on an 8-bit register port, one register per offset
`ifndef SSU_REGS_VH
`define SSU_REGS_VH
// register offsets
`define SSU_A_BUF     4'h0
`define SSU_A_RLD     4'h1
`define SSU_A_CTL1    4'h2
`define SSU_A_CTL2    4'h3
`define SSU_A_CTL3    4'h4
`define SSU_A_MSK     4'h5
`define SSU_A_STAT    4'h6
`define SSU_A_FLAG    4'h7
// control one fields
`define SSU_C1_WCOL   7
`define SSU_C1_OVF    6
`define SSU_C1_ON     5
`define SSU_C1_POL    4
// control two fields
`define SSU_C2_ACKST  6
`define SSU_C2_RCV    3
`define SSU_C2_STOP   2
// flag register fields
`define SSU_F_EVT     0
`define SSU_F_COLL    1
// mode codes
`define SSU_M_SPI4    4'h0
`define SSU_M_SPI16   4'h1
`define SSU_M_SPI64   4'h2
`define SSU_M_SPIR    4'hA
`define SSU_M_TWM     4'h8
`define SSU_M_TWFW    4'hB
// reload equivalents of the fixed spi rates
`define SSU_RLD_F4    8'h00
`define SSU_RLD_F16   8'h03
`define SSU_RLD_F64   8'h0F
// reset values and bit counts
`define SSU_RST_REG   8'h00
`define SSU_LAST_BIT  4'h7
`define SSU_ACK_BIT   4'h8
`define SSU_SPI_LAST  4'hF
`endif

//--- hw/ssu_core.v
// Purpose: rate counter, byte engines, stop sequence and status of the sync serial unit
// Assumes: one clock; bus wires resolved outside from the open-drain enables
// Notes: start, restart and acknowledge sequences live outside; their request bits are kept here
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "ssu_regs.vh"

module ssu_core (
  // clock and reset
  input  wire       clock,
  input  wire       nrst,
  input  wire       clk_en,
  // register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // two-wire pins
  input  wire       scl_in,
  output wire       scl_out,
  output wire       scl_oe_n,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_n,
  // spi pins
  output wire       sck_out,
  output wire       sdo_out,
  input  wire       sdi_in,
  // slave address logic
  input  wire       slv_addr_match,
  input  wire       slv_addr_rw,
  input  wire       slv_nack,
  input  wire       slv_addr_update,
  // flags and pad controls
  output wire       collision_flag,
  output wire       port_event_flag,
  output wire       slew_ctl_en,
  output wire       smbus_levels
);

  // one-hot sequencer states
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_SPI  = 8'h02;
  localparam [7:0] ST_TX   = 8'h04;
  localparam [7:0] ST_RX   = 8'h08;
  localparam [7:0] ST_P1   = 8'h10;
  localparam [7:0] ST_P2   = 8'h20;
  localparam [7:0] ST_P3   = 8'h40;
  localparam [7:0] ST_P4   = 8'h80;

  reg  [7:0] buf_q;
  reg  [7:0] rld_q;
  reg  [7:0] c1_q;
  reg  [7:0] c2_q;
  reg  [7:0] c3_q;
  reg  [7:0] msk_q;
  reg        phase_q;
  reg        edge_q;
  reg        da_q;
  reg        p_q;
  reg        s_q;
  reg        rw_q;
  reg        ua_q;
  reg        bf_q;
  reg        evt_q;
  reg        bcl_q;
  reg  [7:0] state_q;
  reg  [7:0] sh_q;
  reg  [7:0] rx_q;
  reg  [7:0] cnt_q;
  reg  [3:0] bit_q;
  reg        hi_q;
  reg        first_q;
  reg        sda_low_q;
  reg        scl_low_q;
  reg        sck_q;
  reg        step_q;
  reg        sda_prev_q;
  wire [2:0] pin_raw;
  wire [2:0] pin_f;

  // pin synchronisers: three flops, change taken once stages two and three agree
  assign pin_raw = {sdi_in, scl_in, sda_in};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg [2:0] sy_q;
      reg       f_q;
      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          sy_q <= 3'h7;
          f_q  <= 1'b1;
        end else if (clk_en) begin
          sy_q <= {sy_q[1:0], pin_raw[gi]};
          if (sy_q[2] == sy_q[1]) begin
            f_q <= sy_q[1];
          end
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  // mode decode
  wire [3:0] mode    = c1_q[3:0];
  wire       port_on = c1_q[`SSU_C1_ON];
  wire       spi_m   = port_on & (mode == `SSU_M_SPI4 | mode == `SSU_M_SPI16 |
                                  mode == `SSU_M_SPI64 | mode == `SSU_M_SPIR);
  wire       tw_m    = port_on & (mode == `SSU_M_TWM);
  wire       tw      = port_on & (mode[2:1] == 2'b11 | mode == `SSU_M_TWM |
                                  mode == `SSU_M_TWFW);
  wire       sda_f   = pin_f[0];
  wire       scl_f   = pin_f[1];
  wire       sdi_f   = pin_f[2];

  // reload source; fixed spi rates map onto equivalent reloads
  wire [7:0] reload = (mode == `SSU_M_SPI4)  ? `SSU_RLD_F4  :
                      (mode == `SSU_M_SPI16) ? `SSU_RLD_F16 :
                      (mode == `SSU_M_SPI64) ? `SSU_RLD_F64 : rld_q;

  // sequencer status terms
  wire idle_all = state_q[0] & (c2_q[4:0] == 5'h00);
  wire tw_eng   = state_q[2] | state_q[3];
  wire tw_hold  = tw_eng & hi_q & ~scl_f;  // clock stretched by another party
  wire brg_load = state_q[0] | state_q[4] | state_q[5] | tw_hold;
  wire expire   = ~brg_load & step_q & (cnt_q == 8'h00);
  wire start_det = scl_f & sda_prev_q & ~sda_f;
  wire stop_det  = scl_f & ~sda_prev_q & sda_f;
  wire buf_wr   = reg_wr & (reg_addr == `SSU_A_BUF);
  wire buf_ok   = ~(spi_m | tw_m) | idle_all;

  // spi edge selection
  wire       lead   = ~bit_q[0];
  wire       chg    = edge_q ? ~lead : lead;
  wire       chg_sh = chg & ~(~edge_q & (bit_q == 4'h0));
  wire       samp   = phase_q ? (chg_sh | (~edge_q & (bit_q == `SSU_SPI_LAST)))
                              : ~chg;
  wire [7:0] rx_nx  = {rx_q[6:0], sdi_f};
  wire [7:0] tw_nx  = {sh_q[6:0], sda_f};

  // collision detection over stop sequence and transmit arbitration
  wire coll_p3  = state_q[6] & ~scl_f;
  wire coll_p4s = state_q[7] & ~scl_f & ~sda_f;
  wire coll_p4d = state_q[7] & expire & ~sda_f;
  wire coll_tx  = state_q[2] & hi_q & expire & (bit_q != `SSU_ACK_BIT) &
                  ~sda_low_q & ~sda_f;
  wire coll     = coll_p3 | coll_p4s | coll_p4d | coll_tx;

  // rate counter: steps every other clock, reloads at each expiry
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= `SSU_RST_REG;
      step_q <= 1'b0;
    end else if (clk_en) begin
      step_q <= ~step_q;
      if (brg_load) begin
        cnt_q <= reload;
      end else if (step_q) begin
        cnt_q <= (cnt_q == 8'h00) ? reload : cnt_q - 8'h01;
      end
    end
  end

  // registers, status and the sequencer
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      buf_q      <= `SSU_RST_REG;
      rld_q      <= `SSU_RST_REG;
      c1_q       <= `SSU_RST_REG;
      c2_q       <= `SSU_RST_REG;
      c3_q       <= `SSU_RST_REG;
      msk_q      <= `SSU_RST_REG;
      phase_q    <= 1'b0;
      edge_q     <= 1'b0;
      da_q       <= 1'b0;
      p_q        <= 1'b0;
      s_q        <= 1'b0;
      rw_q       <= 1'b0;
      ua_q       <= 1'b0;
      bf_q       <= 1'b0;
      evt_q      <= 1'b0;
      bcl_q      <= 1'b0;
      state_q    <= ST_IDLE;
      sh_q       <= `SSU_RST_REG;
      rx_q       <= `SSU_RST_REG;
      bit_q      <= 4'h0;
      hi_q       <= 1'b0;
      first_q    <= 1'b0;
      sda_low_q  <= 1'b0;
      scl_low_q  <= 1'b0;
      sck_q      <= 1'b0;
      sda_prev_q <= 1'b1;
    end else if (clk_en) begin
      sda_prev_q <= sda_f;
      // software writes; hardware sets below take priority
      if (reg_wr) begin
        case (reg_addr)
          `SSU_A_RLD: begin
            rld_q <= reg_wdata;
            ua_q  <= 1'b0;
          end
          `SSU_A_CTL1: begin
            c1_q <= {c1_q[7] & reg_wdata[7], c1_q[6] & reg_wdata[6], reg_wdata[5:0]};
          end
          `SSU_A_CTL2: begin
            c2_q[7] <= reg_wdata[7];
            c2_q[5] <= reg_wdata[5];
            c2_q[4:0] <= (idle_all & tw_m) ? reg_wdata[4:0] : (c2_q[4:0] & reg_wdata[4:0]);
          end
          `SSU_A_CTL3: begin
            c3_q <= reg_wdata;
          end
          `SSU_A_MSK: begin
            msk_q <= reg_wdata;
          end
          `SSU_A_STAT: begin
            phase_q <= reg_wdata[7];
            edge_q  <= reg_wdata[6];
          end
          `SSU_A_FLAG: begin
            evt_q <= evt_q & ~reg_wdata[`SSU_F_EVT];
            bcl_q <= bcl_q & ~reg_wdata[`SSU_F_COLL];
          end
          default: begin
          end
        endcase
      end
      // reading the buffer empties it
      if (reg_rd & (reg_addr == `SSU_A_BUF)) begin
        bf_q <= 1'b0;
      end
      // slave address results
      if (slv_addr_match) begin
        rw_q <= slv_addr_rw;
        da_q <= 1'b0;
      end
      if (slv_nack & ~tw_m) begin
        rw_q <= 1'b0;
      end
      if (slv_addr_update & mode[0] & tw) begin
        ua_q <= 1'b1;
      end
      // bus monitor for start and stop
      if (start_det & tw) begin
        s_q     <= 1'b1;
        p_q     <= 1'b0;
        first_q <= 1'b1;
        if (!tw_m) begin
          rw_q <= 1'b0;
        end
      end
      if (stop_det & tw) begin
        p_q <= 1'b1;
        s_q <= 1'b0;
        if (!tw_m) begin
          rw_q <= 1'b0;
        end
      end
      // buffer write: store and start, or refuse while busy
      if (buf_wr) begin
        if (!buf_ok) begin
          c1_q[`SSU_C1_WCOL] <= 1'b1;
        end else begin
          buf_q <= reg_wdata;
          if (spi_m) begin
            state_q <= ST_SPI;
            sh_q    <= reg_wdata;
            bit_q   <= 4'h0;
            sck_q   <= c1_q[`SSU_C1_POL];
          end else if (tw_m) begin
            state_q   <= ST_TX;
            sh_q      <= reg_wdata;
            bit_q     <= 4'h0;
            hi_q      <= 1'b0;
            sda_low_q <= ~reg_wdata[7];
            scl_low_q <= 1'b1;
            bf_q      <= 1'b1;
            rw_q      <= 1'b1;
            da_q      <= ~first_q;
            first_q   <= 1'b0;
          end
        end
      end
      case (state_q)
        ST_IDLE: begin
          if (tw_m & c2_q[`SSU_C2_STOP]) begin
            state_q   <= ST_P1;
            sda_low_q <= 1'b1;
            scl_low_q <= 1'b1;
          end else if (tw_m & c2_q[`SSU_C2_RCV]) begin
            state_q   <= ST_RX;
            bit_q     <= 4'h0;
            hi_q      <= 1'b0;
            sda_low_q <= 1'b0;
            scl_low_q <= 1'b1;
          end
        end
        ST_SPI: begin
          if (expire) begin
            bit_q <= bit_q + 4'h1;
            sck_q <= ~sck_q;
            if (chg_sh) begin
              sh_q <= {sh_q[6:0], 1'b0};
            end
            if (samp) begin
              rx_q <= rx_nx;
            end
            if (bit_q == `SSU_SPI_LAST) begin
              buf_q   <= samp ? rx_nx : rx_q;
              bf_q    <= 1'b1;
              evt_q   <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_TX, ST_RX: begin
          if (expire) begin
            if (!hi_q) begin
              scl_low_q <= 1'b0;
              hi_q      <= 1'b1;
            end else begin
              sh_q      <= tw_nx;
              bit_q     <= bit_q + 4'h1;
              hi_q      <= 1'b0;
              scl_low_q <= 1'b1;
              if (state_q[3] & (bit_q == `SSU_LAST_BIT)) begin
                buf_q <= tw_nx;
                if (bf_q) begin
                  c1_q[`SSU_C1_OVF] <= 1'b1;
                end
                bf_q    <= 1'b1;
                da_q    <= 1'b1;
                c2_q[`SSU_C2_RCV] <= 1'b0;
                evt_q   <= 1'b1;
                state_q <= ST_IDLE;
              end else if (bit_q == `SSU_ACK_BIT) begin
                c2_q[`SSU_C2_ACKST] <= sda_f;
                rw_q    <= 1'b0;
                evt_q   <= 1'b1;
                state_q <= ST_IDLE;
              end else begin
                sda_low_q <= state_q[2] & (bit_q != `SSU_LAST_BIT) & ~sh_q[6];
                if (state_q[2] & (bit_q == `SSU_LAST_BIT)) begin
                  bf_q <= 1'b0;
                end
              end
            end
          end
        end
        ST_P1: begin
          if (!sda_f) begin
            scl_low_q <= 1'b0;
            state_q   <= ST_P2;
          end
        end
        ST_P2: begin
          if (scl_f) begin
            state_q <= ST_P3;
          end
        end
        ST_P3: begin
          if (expire) begin
            sda_low_q <= 1'b0;
            state_q   <= ST_P4;
          end
        end
        ST_P4: begin
          if (expire & sda_f) begin
            c2_q[`SSU_C2_STOP] <= 1'b0;
            evt_q   <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // collision abort
      if (coll) begin
        bcl_q     <= 1'b1;
        state_q   <= ST_IDLE;
        sda_low_q <= 1'b0;
        scl_low_q <= 1'b0;
        c2_q[4:0] <= 5'h00;
        bf_q      <= 1'b0;
        rw_q      <= 1'b0;
      end
      // port off forces idle and clears bus state
      if (!port_on) begin
        state_q   <= ST_IDLE;
        s_q       <= 1'b0;
        p_q       <= 1'b0;
        sda_low_q <= 1'b0;
        scl_low_q <= 1'b0;
        c2_q[4:0] <= 5'h00;
      end
    end
  end

  // read data, one cycle after the read strobe
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `SSU_RST_REG;
    end else if (clk_en) begin
      if (reg_rd) begin
        case (reg_addr)
          `SSU_A_BUF:  reg_rdata <= buf_q;
          `SSU_A_RLD:  reg_rdata <= rld_q;
          `SSU_A_CTL1: reg_rdata <= c1_q;
          `SSU_A_CTL2: reg_rdata <= c2_q;
          `SSU_A_CTL3: reg_rdata <= c3_q;
          `SSU_A_MSK:  reg_rdata <= msk_q;
          `SSU_A_STAT: reg_rdata <= {phase_q, edge_q, da_q, p_q, s_q, rw_q, ua_q, bf_q};
          `SSU_A_FLAG: reg_rdata <= {6'h00, bcl_q, evt_q};
          default:     reg_rdata <= `SSU_RST_REG;
        endcase
      end else begin
        reg_rdata <= `SSU_RST_REG;
      end
    end
  end

  // pin drive: two-wire pins open drain, pulling low only; spi clock and data driven both ways
  assign sda_out         = 1'b0;
  assign sda_oe_n        = ~sda_low_q;
  assign scl_out         = 1'b0;
  assign scl_oe_n        = ~scl_low_q;
  assign sck_out         = sck_q;
  assign sdo_out         = spi_m & sh_q[7];
  // flags and pad controls
  assign collision_flag  = bcl_q;
  assign port_event_flag = evt_q;
  assign slew_ctl_en     = tw & ~phase_q;
  assign smbus_levels    = tw & edge_q;

endmodule // ssu_core

//--- verif/ssu_core_sva.sv
// Purpose: port-level checker for the sync serial unit core
// Assumes: shadows of reload, control one and status follow register writes
// Notes: bound to every ssu_core instance
`timescale 1ns/1ps
module ssu_core_sva (
  // clock and reset
  input wire       clock,
  input wire       nrst,
  input wire       clk_en,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // pins and flags
  input wire       scl_oe_n,
  input wire       sda_oe_n,
  input wire       sck_out,
  input wire       collision_flag,
  input wire       port_event_flag,
  input wire       slew_ctl_en,
  input wire       smbus_levels
);
  reg [7:0] rld_q;
  reg [7:0] ctl_q;
  reg [7:0] st_q;
  reg       sck_q;
  reg [8:0] gap_q;
  wire      tw;
  wire      clr_c;
  wire      clr_e;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // shadow of software-written fields
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rld_q <= 8'h00;
      ctl_q <= 8'h00;
      st_q  <= 8'h00;
    end else if (reg_wr && clk_en) begin
      case (reg_addr)
        4'h1: rld_q <= reg_wdata;
        4'h2: ctl_q <= reg_wdata;
        4'h6: st_q  <= reg_wdata;
        default: ;
      endcase
    end
  end
  // cycles since the last serial clock change
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 1'b0;
      gap_q <= 9'h000;
    end else begin
      sck_q <= sck_out;
      gap_q <= (sck_out != sck_q) ? 9'h000 : (gap_q == 9'h1FF) ? gap_q : gap_q + 9'h001;
    end
  end
  // two-wire modes: 6,7,8,B,E,F
  assign tw = ctl_q[5] && (ctl_q[3:0] inside {4'h6, 4'h7, 4'h8, 4'hB, 4'hE, 4'hF});
  assign clr_c = reg_wr && reg_addr == 4'h7 && reg_wdata[1];
  assign clr_e = reg_wr && reg_addr == 4'h7 && reg_wdata[0];
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_coll_hold: assert property (collision_flag && !clr_c |=> collision_flag)
    else $error("collision flag dropped without clear");
  a_event_hold: assert property (port_event_flag && !clr_e |=> port_event_flag)
    else $error("event flag dropped without clear");
  a_coll_release: assert property ($rose(collision_flag) |-> ##[0:2] (scl_oe_n && sda_oe_n))
    else $error("lines not released after collision");
  a_slew_mode: assert property (ctl_q[5] |-> slew_ctl_en == (tw && !st_q[7]))
    else $error("slew control wrong");
  a_smbus_mode: assert property (ctl_q[5] |-> smbus_levels == (tw && st_q[6]))
    else $error("input level select wrong");
  a_sck_gap: assert property ((sck_out != sck_q) && ctl_q[3:0] == 4'hA |-> gap_q >= {rld_q, 1'b1})
    else $error("serial clock half period too short");
  c_coll: cover property ($rose(collision_flag));
  c_event: cover property ($rose(port_event_flag));
  c_sck: cover property ((sck_out != sck_q) && ctl_q[3:0] == 4'hA);
endmodule // ssu_core_sva
bind ssu_core ssu_core_sva chk_u (.clock(clock), .nrst(nrst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .sck_out(sck_out),
  .collision_flag(collision_flag), .port_event_flag(port_event_flag),
  .slew_ctl_en(slew_ctl_en), .smbus_levels(smbus_levels));

//--- verif/ssu_bus_peer.sv
// Purpose: far side of the two-wire bus with pull-ups and a rival master
// Assumes: design pins are open drain, enables active low
// Notes: a rival master may hold either line low on command
`timescale 1ns/1ps
module ssu_bus_peer (
  // design pin enables
  input  wire scl_oe_n,
  input  wire sda_oe_n,
  // rival master pulling lines low
  input  wire hold_scl,
  input  wire hold_sda,
  // resolved wire levels
  output wire scl,
  output wire sda
);
  // pull-ups win unless someone pulls low
  assign scl = scl_oe_n & ~hold_scl;
  assign sda = sda_oe_n & ~hold_sda;
endmodule // ssu_bus_peer

//--- verif/ssu_core_tb.sv
// Purpose: register-level tests of the sync serial unit core
// Assumes: spi data out looped to spi data in
// Notes: clk_en held high throughout
`timescale 1ns/1ps
module ssu_core_tb;
  reg        clock, nrst, reg_wr, reg_rd, hold_scl, hold_sda, m_match, m_rw, m_nack, m_upd;
  reg  [3:0] reg_addr;
  reg  [7:0] reg_wdata, d;
  wire [7:0] reg_rdata;
  wire       scl, sda, scl_oe_n, sda_oe_n, sck, sdo, coll, evt, slew, smb;
  integer    bad_count, n_tests, cyc, i;
  ssu_bus_peer peer_u (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .hold_scl(hold_scl),
    .hold_sda(hold_sda), .scl(scl), .sda(sda));
  ssu_core dut_u (.clock(clock), .nrst(nrst), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(),
    .sda_oe_n(sda_oe_n), .sck_out(sck), .sdo_out(sdo), .sdi_in(sdo),
    .slv_addr_match(m_match), .slv_addr_rw(m_rw), .slv_nack(m_nack),
    .slv_addr_update(m_upd), .collision_flag(coll), .port_event_flag(evt),
    .slew_ctl_en(slew), .smbus_levels(smb));
  // register bus cycles
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clock);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clock);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // wait: 0 event flag, 1 collision, 2 sda pulled
  task wt(input integer k);
    integer n;
    begin
      n = 0;
      while (!(k == 0 ? evt === 1'b1 : k == 1 ? coll === 1'b1 : sda_oe_n === 1'b0) && n < 800) begin
        @(posedge clock);
        #1 n = n + 1;
      end
      if (n == 800) chk(8'h00, 8'h01);
    end
  endtask
  task pul(input [2:0] m);
    begin
      @(posedge clock);
      {m_upd, m_nack, m_match} <= m;
      @(posedge clock);
      {m_upd, m_nack, m_match} <= 3'h0;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // run ceiling
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  // main sequence
  initial begin
    {nrst, reg_wr, reg_rd, hold_scl, hold_sda, m_match, m_rw, m_nack, m_upd} = 9'h000;
    reg_addr = 4'h0; reg_wdata = 8'h00; bad_count = 0; n_tests = 0; cyc = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd(4'h6); chk(d, 8'h00);
    rd(4'h7); chk(d, 8'h00);
    rd(4'hF); chk(d, 8'h00);
    wr(4'h1, 8'h13); rd(4'h1); chk(d, 8'h13);
    $display("test reset done");
    wr(4'h2, 8'h2A); wr(4'h1, 8'h03); wr(4'h0, 8'hA5);
    i = 0;
    while (sck !== 1'b1 && i < 100) begin @(posedge clock); #1 i = i + 1; end
    i = 0;
    while (sck !== 1'b0 && i < 100) begin @(posedge clock); #1 i = i + 1; end
    chk(i[7:0], 8'h08);
    wt(0); repeat (20) @(posedge clock);
    chk({7'h00, sck}, 8'h00);
    rd(4'h6); chk(d & 8'h01, 8'h01);
    rd(4'h0); chk(d, 8'hA5);
    rd(4'h6); chk(d & 8'h01, 8'h00);
    wr(4'h7, 8'h03); wr(4'h6, 8'hC0); wr(4'h0, 8'h3C); wt(0);
    rd(4'h0); chk(d, 8'h3C);
    wr(4'h6, 8'h00); wr(4'h7, 8'h03);
    $display("test spi done");
    wr(4'h2, 8'h28); wr(4'h1, 8'h09);
    chk({7'h00, slew}, 8'h01);
    wr(4'h6, 8'hC0); #1 chk({6'h00, slew, smb}, 8'h01);
    wr(4'h6, 8'h00); wr(4'h0, 8'h55);
    rd(4'h6); chk(d & 8'h25, 8'h25);
    wt(0); rd(4'h6); chk(d & 8'h25, 8'h20);
    wr(4'h7, 8'h03); wr(4'h3, 8'h04); wt(0);
    rd(4'h3); chk(d & 8'h1F, 8'h00);
    rd(4'h6); chk(d & 8'h18, 8'h10);
    wr(4'h7, 8'h03); hold_sda <= 1'b1; wr(4'h3, 8'h04); wt(1);
    rd(4'h3); chk(d & 8'h1F, 8'h00);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    hold_sda <= 1'b0; wr(4'h7, 8'h03); wr(4'h3, 8'h04); wt(2);
    repeat (8) @(posedge clock);
    hold_scl <= 1'b1; wt(1);
    rd(4'h3); chk(d & 8'h1F, 8'h00);
    hold_scl <= 1'b0; wr(4'h7, 8'h03); wr(4'h3, 8'h08); wt(0);
    rd(4'h6); chk(d & 8'h21, 8'h21);
    rd(4'h0); chk(d, 8'hFF);
    wr(4'h2, 8'h08);
    rd(4'h6); chk(d & 8'h18, 8'h00);
    $display("test two-wire done");
    wr(4'h2, 8'h27); m_rw <= 1'b1; pul(3'h1);
    rd(4'h6); chk(d & 8'h04, 8'h04);
    pul(3'h2); rd(4'h6); chk(d & 8'h04, 8'h00);
    pul(3'h4); rd(4'h6); chk(d & 8'h02, 8'h02);
    wr(4'h1, 8'h09); rd(4'h6); chk(d & 8'h02, 8'h00);
    $display("test slave done");
    complete_run;
  end
endmodule // ssu_core_tb
